// ---- dv/srg_motor_model.sv ----
// Behavioural motor driver stage that counts step commands
`timescale 1ns/1ps

module srg_motor_model
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Step link from the ramp generator
    input wire logic step_pulse,
    input wire logic step_dir,
    // What the stage has seen
    output int steps,
    output int position,
    output int gap
);
    int since;

    // Each pulse moves one microstep; spacing is kept for rate checks
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            steps <= 0;
            position <= 0;
            gap <= 0;
            since <= 0;
        end
        else if (step_pulse === 1'b1)
        begin
            steps <= steps + 1;
            position <= step_dir ? position + 1 : position - 1;
            gap <= since + 1;
            since <= 0;
        end
        else
            since <= since + 1;
    end
endmodule

// ---- dv/srg_ramp_gen_asserts.sv ----
// Port-level assertion checker for the ramp generator
`timescale 1ns/1ps

module srg_ramp_gen_asserts
import srg_pkg::*;
#(
    parameter int WAIT_UNIT_CYC = 4
)
(
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [srg_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Motor driver side
    input wire logic step_pulse,
    input wire logic step_dir,
    input wire logic [3:0] microstep_code,
    input wire logic motion_busy
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [PW-1:0] wait_reg;
    logic [31:0] gap_reg;
    logic wr_hit;
    logic bad_addr;

    // Completed writes; the wait setting is snooped off the bus
    assign wr_hit = psel && penable && pwrite && pready;
    assign bad_addr = paddr > OFS_STAT || paddr[1:0] != 2'b00;

    // Cycles since the last step bound the settle time before idle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_reg <= '0;
            gap_reg <= '0;
        end
        else
        begin
            if (wr_hit && paddr == OFS_PARL)
                wait_reg <= pwdata[PW-1:0];
            gap_reg <= step_pulse ? 32'h0 : gap_reg + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Command taken while idle, then motion held for two cycles
    sequence s_start;
        wr_hit && paddr == OFS_CMD && pwdata[1:0] != 2'b00 && !motion_busy;
    endsequence
    sequence s_busy;
        motion_busy ##1 motion_busy;
    endsequence

    AST_CMD_START: assert property (s_start |-> ##[1:2] s_busy)
        else $error("command from idle did not start motion");
    AST_STEP_BUSY: assert property (step_pulse |-> motion_busy)
        else $error("step issued while idle");
    AST_DIR_HOLD: assert property
        (motion_busy && $past(motion_busy) |-> $stable(step_dir))
        else $error("direction changed during a motion");
    AST_WAIT_HOLD: assert property
        ($fell(motion_busy) |-> gap_reg >= wait_reg * WAIT_UNIT_CYC)
        else $error("idle reached before the wait time ran out");
    AST_USTEP_RANGE: assert property
        (microstep_code <= USTEP_MAX)
        else $error("microstep code beyond the finest resolution");
    AST_USTEP_WRITE: assert property
        (wr_hit && paddr == OFS_USTEP && pwdata[3:0] <= USTEP_MAX
            |=> microstep_code == $past(pwdata[3:0]))
        else $error("microstep code not taken from the bus");
    AST_USTEP_KEEP: assert property
        (wr_hit && paddr == OFS_USTEP && pwdata[3:0] > USTEP_MAX
            |=> $stable(microstep_code))
        else $error("illegal microstep code was accepted");
    AST_BAD_ADDR: assert property
        (psel && penable && bad_addr |-> pslverr)
        else $error("unmapped access without error");
    AST_GOOD_ADDR: assert property
        (psel && penable && !bad_addr |-> !pslverr)
        else $error("mapped access flagged as error");
endmodule

bind srg_ramp_gen srg_ramp_gen_asserts #(.WAIT_UNIT_CYC(WAIT_UNIT_CYC))
    i_srg_ramp_gen_asserts (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_pulse(step_pulse), .step_dir(step_dir),
    .microstep_code(microstep_code), .motion_busy(motion_busy));

// ---- dv/srg_ramp_gen_tb.sv ----
// Self-checking bench for the ramp generator
`timescale 1ns/1ps

module srg_ramp_gen_tb;
    import srg_pkg::*;
    localparam int WU = 4;
    localparam logic [31:0] V = 32'h004c4b40;  // Ten clocks per step
    localparam logic [31:0] VI = 32'h00100000;  // Sixteen clocks per step
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, step_pulse, step_dir, motion_busy, err;
    logic [3:0] microstep_code;
    int steps, position, gap;
    int failures = 0;
    int check_count = 0;

    srg_ramp_gen #(.WAIT_UNIT_CYC(WU)) i_srg_ramp_gen (.pclk(pclk),
        .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .step_pulse(step_pulse),
        .step_dir(step_dir), .microstep_code(microstep_code),
        .motion_busy(motion_busy));
    srg_motor_model i_srg_motor_model (.pclk(pclk), .presetn(presetn),
        .step_pulse(step_pulse), .step_dir(step_dir), .steps(steps),
        .position(position), .gap(gap));

    // Free-running clock
    always #10 pclk = ~pclk;

    task automatic chk(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; an idle cycle follows so strobes never collide
    task automatic apb(input logic wr, input logic [AW-1:0] a,
        input logic [31:0] d);
        int t;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (t = 0; t < 50 && pready !== 1'b1; t++) @(posedge pclk);
        if (pready !== 1'b1)
        begin
            failures++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_busy(input logic lvl);
        int t;
        for (t = 0; t < 5000 && motion_busy !== lvl; t++) @(posedge pclk);
        chk("busy", {31'h0, motion_busy}, {31'h0, lvl});
    endtask

    // Accelerations of one keep the rate flat; wait is two units
    task automatic set_par(input logic [31:0] vs, vb, vt, vp, d);
        logic [31:0] p [NPAR];
        p = '{vs, 32'h1, vb, 32'h1, vt, d, d, vp, 32'h2};
        for (int i = 0; i < NPAR; i++)
            apb(1'b1, OFS_PAR0 + 8'(4 * i), p[i]);
    endtask

    task automatic move(input logic [31:0] tgt, dn, per, input logic dir);
        int s0;
        s0 = steps;
        apb(1'b1, OFS_TARGET, tgt);
        apb(1'b1, OFS_CMD, 32'h3);
        wait_busy(1'b1);
        wait_busy(1'b0);
        apb(1'b0, OFS_POS, '0);
        chk("position", rd, tgt);
        chk("step count", 32'(steps - s0), dn);
        chk("step spacing", 32'(gap), per);
        chk("direction", {31'h0, step_dir}, {31'h0, dir});
    endtask

    task automatic end_of_test();
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, then every parameter keeps 24 bits only
        apb(1'b0, OFS_UNIT, '0);
        chk("unit reset", rd, 32'h1);
        apb(1'b0, OFS_USTEP, '0);
        chk("ustep reset", rd, 32'h8);
        for (int i = 0; i < NPAR; i++)
        begin
            apb(1'b0, OFS_PAR0 + 8'(4 * i), '0);
            chk("param reset", rd, '0);
            apb(1'b1, OFS_PAR0 + 8'(4 * i), 32'hff000000 + 32'(i + 3));
            apb(1'b0, OFS_PAR0 + 8'(4 * i), '0);
            chk("param field", rd, 32'(i + 3));
        end
        // Codes above 256 microsteps are refused
        apb(1'b1, OFS_USTEP, 32'h9);
        chk("ustep over", {28'h0, microstep_code}, 32'h8);
        apb(1'b1, OFS_USTEP, 32'h4);
        chk("ustep set", {28'h0, microstep_code}, 32'h4);
        apb(1'b1, OFS_USTEP, 32'h8);
        // Unmapped and misaligned places answer with an error
        apb(1'b0, 8'h40, '0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, '0);
        apb(1'b1, 8'h09, 32'h5);
        apb(1'b0, OFS_PAR0, '0);
        chk("misaligned write", rd, 32'h3);
        // Trapezoid out, six segments back, in step units
        set_par(V, 32'h0, V, V, 32'h1);
        move(32'd12, 32'd12, CLK_HZ / V, 1'b1);
        set_par(V, V, V, V, 32'h1);
        move(32'd0, 32'd12, CLK_HZ / V, 1'b0);
        // Internal units wrap the rate accumulator at 2^24
        apb(1'b1, OFS_UNIT, '0);
        apb(1'b0, OFS_UNIT, '0);
        chk("unit set", rd, '0);
        set_par(VI, 32'h0, VI, VI, 32'h1);
        move(32'd8, 32'd8, 32'(MOD_INT) / VI, 1'b1);
        // Rotation: start above top is clamped, decels left unused
        apb(1'b1, OFS_UNIT, 32'h1);
        set_par(2 * V, 32'h0, V, V, 32'hffffff);
        apb(1'b1, OFS_TARGET, 2 * V);
        for (int op = 1; op <= 2; op++)
        begin
            apb(1'b1, OFS_CMD, 32'(op));
            wait_busy(1'b1);
            repeat (300) @(posedge pclk);
            chk("rotate spacing", 32'(gap), CLK_HZ / V);
            chk("rotate dir", {31'h0, step_dir}, 32'(op == 1));
            apb(1'b1, OFS_CMD, 32'h0);
            wait_busy(1'b0);
            apb(1'b0, OFS_POS, '0);
            chk("rotate pos", rd, 32'(position));
        end
        end_of_test();
    end

    // Watchdog, well beyond the under two thousand cycles the run needs
    initial
    begin
        #1000000;
        failures++;
        end_of_test();
    end
endmodule

// ---- rtl/srg_pkg.sv ----
// Shared constants and types of the ramp generator
package srg_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PW = 24;   // velocity, acceleration, wait fields
    localparam int AW = 8;    // APB address bits decoded
    localparam int MW = 26;   // step and ramp accumulator width

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int CLK_HZ = CLK_MHZ * 1000000;
    localparam int WAIT_UNIT_US = 1000;  // one wait-time unit, in us
    localparam int WAIT_UNIT_DEF = WAIT_UNIT_US * CLK_MHZ;
    // Accumulator moduli: one second of clocks, or the internal unit
    localparam logic [MW-1:0] MOD_PPS = MW'(CLK_HZ);
    localparam logic [MW-1:0] MOD_INT = 26'h1000000;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [AW-1:0] OFS_UNIT = 8'h00;
    localparam logic [AW-1:0] OFS_USTEP = 8'h04;
    localparam logic [AW-1:0] OFS_PAR0 = 8'h08;
    localparam logic [AW-1:0] OFS_PARL = 8'h28;
    localparam logic [AW-1:0] OFS_TARGET = 8'h2c;
    localparam logic [AW-1:0] OFS_CMD = 8'h30;
    localparam logic [AW-1:0] OFS_POS = 8'h34;
    localparam logic [AW-1:0] OFS_VEL = 8'h38;
    localparam logic [AW-1:0] OFS_STAT = 8'h3c;

    // Index of each ramp parameter inside the parameter array
    localparam int P_START_VELOCITY = 0;
    localparam int P_A1 = 1;
    localparam int P_VBRK = 2;
    localparam int P_A2 = 3;
    localparam int P_VTOP = 4;
    localparam int P_D2 = 5;
    localparam int P_D1 = 6;
    localparam int P_STOP_VELOCITY = 7;
    localparam int P_WAIT = 8;
    localparam int NPAR = 9;

    // Reset values and limits
    localparam logic UNIT_RST = 1'b1;
    localparam logic [3:0] USTEP_RST = 4'h8;
    localparam logic [3:0] USTEP_MAX = 4'h8;

    // ------------------------------------------------------------
    // Enumerations and state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_STOP = 2'b00,
        OP_RIGHT = 2'b01,
        OP_LEFT = 2'b10,
        OP_MOVE = 2'b11
    } srg_op_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_RUN = 2'b01,
        S_DECEL = 2'b10,
        S_WAIT = 2'b11
    } srg_state_t;

    typedef struct packed {
        logic unit;
        logic [3:0] ustep;
        logic [NPAR-1:0][PW-1:0] par;
        logic [31:0] target;
        logic [31:0] tgt;
        logic [PW-1:0] spd;
        srg_state_t st;
        logic posm;
        logic dir;
        logic pend;
        srg_op_t pop;
        logic [31:0] pos;
        logic [PW-1:0] vel;
        logic [MW-1:0] sacc;
        logic [MW-1:0] aacc;
        logic [PW-1:0] wcnt;
        logic [15:0] ucnt;
        logic step;
        logic [31:0] prd;
    } srg_regs_t;

    localparam srg_regs_t REGS_RST = '{
        unit: UNIT_RST,
        ustep: USTEP_RST,
        st: S_IDLE,
        pop: OP_STOP,
        default: '0
    };

endpackage

// ---- rtl/srg_ramp_gen.sv ----
// Per-axis velocity ramp generator with APB register access
//
// How it works
// - Unit mode 1, the reset default, takes velocities in pps, accels pps2.
// - Unit mode 0 uses values directly as internal ramp units.
// - Microstep code resets to 8, meaning 256 microsteps per full step.
// - Nine per-axis ramp parameters configure the ramp.
// - Zero break velocity disables six segments; a trapezoid is used.
// - Six-segment profile applies to move-to-position only.
// - Rotation uses a trapezoid: second accel, speed, start, stop velocity.
// - Rotation ignores both deceleration parameters.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps

module srg_ramp_gen
#(
    parameter int WAIT_UNIT_CYC = srg_pkg::WAIT_UNIT_DEF
)
(
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [srg_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Motor driver stage
    output logic step_pulse,
    output logic step_dir,
    output logic [3:0] microstep_code,
    output logic motion_busy
);
    import srg_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [47:0] sq(input logic [PW-1:0] x);
        sq = 48'(x) * 48'(x);
    endfunction

    function automatic logic [PW-1:0] vmin(input logic [PW-1:0] a,
                                           input logic [PW-1:0] b);
        vmin = (a < b) ? a : b;
    endfunction

    // ------------------------------------------------------------
    // State and working signals
    // ------------------------------------------------------------
    srg_regs_t r;
    srg_regs_t n;

    logic wr;
    logic setup;
    logic par_hit;
    logic mapped;
    logic [3:0] pidx;
    logic [31:0] rdata;
    logic six_on;
    logic [MW-1:0] modulus;
    logic [PW-1:0] vtop;
    logic [PW-1:0] stop_velocity;
    logic [PW-1:0] vfloor;
    logic [PW-1:0] vgoal;
    logic [PW-1:0] arate;
    logic [PW-1:0] drate;
    logic [PW-1:0] rate;
    logic [PW-1:0] da;
    logic [PW-1:0] db;
    logic [PW-1:0] vb;
    logic [PW-1:0] vs;
    logic [31:0] rem;
    logic [47:0] hi;
    logic [47:0] lo;
    logic [87:0] lhs;
    logic [87:0] rhs;
    logic brake;
    logic [MW:0] ssum;
    logic [MW:0] asum;
    logic moving;
    logic stepped;
    logic [31:0] pos_step;
    logic arrive;
    logic mdir;
    logic same;
    logic stop_now;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Answer in the access phase; stalled while the clock enable is low
    assign pready = ce;
    assign wr = psel & penable & pwrite & ce;
    assign setup = psel & ~penable & ce;
    // Misaligned places inside the parameter range must not alias a word
    assign par_hit = (paddr >= OFS_PAR0) && (paddr <= OFS_PARL)
                     && (paddr[1:0] == 2'b00);
    assign pidx = 4'((paddr - OFS_PAR0) >> 2);
    assign mapped = (paddr <= OFS_STAT) && (paddr[1:0] == 2'b00);
    assign pslverr = psel & penable & ~mapped;

    // Read mux; latched in the setup phase so read data comes from flops
    always_comb
    begin
        rdata = '0;
        if (par_hit)
        begin
            rdata = 32'(r.par[pidx]);
        end
        else
        begin
            unique case (paddr)
                OFS_UNIT: rdata = 32'(r.unit);
                OFS_USTEP: rdata = 32'(r.ustep);
                OFS_TARGET: rdata = r.target;
                OFS_CMD: rdata = 32'({r.pend, r.pop});
                OFS_POS: rdata = r.pos;
                OFS_VEL: rdata = 32'(r.vel);
                OFS_STAT: rdata = 32'({r.posm, r.dir, r.pend, r.st});
                default: rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Ramp selection
    // ------------------------------------------------------------
    // Units pick the accumulator modulus; one adder serves both modes
    assign modulus = r.unit ? MOD_PPS : MOD_INT;
    assign six_on = r.posm && (r.par[P_VBRK] != '0);
    assign vtop = r.par[P_VTOP];
    assign stop_velocity = r.par[P_STOP_VELOCITY];
    // A zero floor would strand a move short of its target
    assign vfloor = (stop_velocity == '0) ? PW'(1) : stop_velocity;

    // Rates: rotation uses the second accel both ways, decels unused
    always_comb
    begin
        if (!r.posm)
        begin
            arate = r.par[P_A2];
            drate = r.par[P_A2];
        end
        else if (six_on)
        begin
            arate = (r.vel < r.par[P_VBRK]) ? r.par[P_A1] : r.par[P_A2];
            drate = (r.vel > r.par[P_VBRK]) ? r.par[P_D2] : r.par[P_D1];
        end
        else
        begin
            arate = r.par[P_A2];
            drate = r.par[P_A1];
        end
    end

    // Velocity goal per state, never above the top velocity
    always_comb
    begin
        if (r.st == S_DECEL)
        begin
            vgoal = r.posm ? vmin(vfloor, vtop) : vmin(stop_velocity, vtop);
        end
        else if (r.posm)
        begin
            vgoal = vtop;
        end
        else
        begin
            vgoal = vmin(r.spd, vtop);
        end
    end
    assign rate = (r.vel < vgoal) ? arate : drate;

    // ------------------------------------------------------------
    // Braking distance
    // ------------------------------------------------------------
    // Brake when remaining steps fit both decel segments, mirrored:
    // rem*2*da*db <= db*(v^2-vb^2) + da*(vb^2-vs^2). Products avoid a
    // divider at the cost of wide multipliers. Same in both unit modes.
    assign rem = r.dir ? (r.tgt - r.pos) : (r.pos - r.tgt);
    assign da = six_on ? r.par[P_D2] : r.par[P_A1];
    assign db = six_on ? r.par[P_D1] : r.par[P_A1];
    assign vb = (six_on && r.vel > r.par[P_VBRK]) ? r.par[P_VBRK] : r.vel;
    assign vs = vmin(stop_velocity, vb);
    assign hi = sq(r.vel) - sq(vb);
    assign lo = sq(vb) - sq(vs);
    assign lhs = 88'({rem, 1'b0}) * 88'(da) * 88'(db);
    assign rhs = 88'(db) * 88'(hi) + 88'(da) * 88'(lo);
    assign brake = (lhs <= rhs);

    // ------------------------------------------------------------
    // Step and ramp accumulators
    // ------------------------------------------------------------
    assign moving = ((r.st == S_RUN) || (r.st == S_DECEL))
                    && (r.vel != '0) && (!r.posm || r.pos != r.tgt);
    assign ssum = {1'b0, r.sacc} + (MW + 1)'(r.vel);
    assign asum = {1'b0, r.aacc} + (MW + 1)'(rate);
    assign stepped = moving && (ssum >= {1'b0, modulus});
    assign pos_step = r.dir ? (r.pos + 32'h1) : (r.pos - 32'h1);
    assign arrive = r.posm && (stepped ? (pos_step == r.tgt)
                                       : (r.pos == r.tgt));

    // Pending command against the motion in progress
    assign mdir = $signed(r.target) > $signed(r.pos);
    always_comb
    begin
        unique case (r.pop)
            OP_MOVE: same = r.posm && (mdir == r.dir)
                            && (r.target != r.pos);
            OP_RIGHT: same = !r.posm && r.dir;
            OP_LEFT: same = !r.posm && !r.dir;
            OP_STOP: same = 1'b0;
        endcase
    end

    // Decel ends at target, or at floor when a new command waits; rotation ends at stop velocity
    assign stop_now = (r.st == S_DECEL) && (r.posm
                      ? (r.pend && r.vel <= vfloor)
                      : (r.vel <= stop_velocity));

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        n = r;
        if (ce)
        begin
            n.step = 1'b0;
            if (setup)
            begin
                n.prd = rdata;
            end

            // Register writes
            if (wr && par_hit)
            begin
                n.par[pidx] = pwdata[PW-1:0];
            end
            else if (wr)
            begin
                unique case (paddr)
                    OFS_UNIT: n.unit = pwdata[0];
                    OFS_USTEP:
                    begin
                        // Codes above 256 microsteps are ignored
                        if (pwdata[3:0] <= USTEP_MAX)
                        begin
                            n.ustep = pwdata[3:0];
                        end
                    end
                    OFS_TARGET: n.target = pwdata;
                    OFS_CMD:
                    begin
                        n.pend = 1'b1;
                        n.pop = srg_op_t'(pwdata[1:0]);
                    end
                    OFS_POS:
                    begin
                        // Only a standing axis may be re-zeroed
                        if (r.st == S_IDLE)
                        begin
                            n.pos = pwdata;
                        end
                    end
                    default: n.pos = r.pos;
                endcase
            end

            // Step emission at the programmed rate
            if (moving)
            begin
                n.sacc = stepped ? MW'(ssum - {1'b0, modulus})
                                 : MW'(ssum);
            end
            if (stepped)
            begin
                n.step = 1'b1;
                n.pos = pos_step;
            end

            // One velocity unit per accumulator wrap caps the accel rate
            if (r.vel != vgoal)
            begin
                if (asum >= {1'b0, modulus})
                begin
                    n.aacc = MW'(asum - {1'b0, modulus});
                    n.vel = (r.vel < vgoal) ? r.vel + PW'(1)
                                            : r.vel - PW'(1);
                end
                else
                begin
                    n.aacc = MW'(asum);
                end
            end
            else
            begin
                n.aacc = '0;
            end

            // Motion sequence
            unique case (r.st)
                S_IDLE:
                begin
                    n.vel = '0;
                    if (r.pend)
                    begin
                        n.pend = 1'b0;
                        n.sacc = '0;
                        n.aacc = '0;
                        if (r.pop == OP_MOVE && r.target != r.pos)
                        begin
                            n.posm = 1'b1;
                            n.dir = mdir;
                            n.tgt = r.target;
                            n.vel = vmin(r.par[P_START_VELOCITY], vtop);
                            n.st = S_RUN;
                        end
                        else if (r.pop == OP_RIGHT || r.pop == OP_LEFT)
                        begin
                            n.posm = 1'b0;
                            n.dir = (r.pop == OP_RIGHT);
                            n.spd = r.target[PW-1:0];
                            n.vel = vmin(r.par[P_START_VELOCITY],
                                         vmin(r.target[PW-1:0], vtop));
                            n.st = S_RUN;
                        end
                    end
                end
                S_RUN:
                begin
                    if (r.pend && same)
                    begin
                        // Same way: retarget on the fly
                        n.pend = 1'b0;
                        n.tgt = r.target;
                        n.spd = r.target[PW-1:0];
                    end
                    else if (r.pend)
                    begin
                        n.pend = (r.pop != OP_STOP);
                        n.st = S_DECEL;
                    end
                    else if (r.posm && brake)
                    begin
                        n.st = S_DECEL;
                    end
                end
                S_DECEL:
                begin
                    n.st = S_DECEL;
                end
                S_WAIT:
                begin
                    // Hold before any new start, so reversals rest
                    n.vel = '0;
                    if (r.wcnt == '0)
                    begin
                        n.st = S_IDLE;
                    end
                    else if (r.ucnt == 16'(WAIT_UNIT_CYC - 1))
                    begin
                        n.ucnt = '0;
                        n.wcnt = r.wcnt - PW'(1);
                    end
                    else
                    begin
                        n.ucnt = r.ucnt + 16'h1;
                    end
                end
            endcase

            // Arrival or end of decel: stop and start the wait time
            if ((r.st == S_RUN || r.st == S_DECEL) && (arrive || stop_now))
            begin
                n.vel = '0;
                n.st = S_WAIT;
                n.wcnt = r.par[P_WAIT];
                n.ucnt = '0;
            end
            else if (n.vel > vtop)
            begin
                n.vel = vtop;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= REGS_RST;
        end
        else
        begin
            r <= n;
        end
    end

    // Outputs from flops; busy is decoded from the state
    assign prdata = r.prd;
    assign step_pulse = r.step;
    assign step_dir = r.dir;
    assign microstep_code = r.ustep;
    assign motion_busy = (r.st != S_IDLE);

endmodule
